// ### logic/rx_sideband_regs.svh
`ifndef RX_SIDEBAND_REGS_SVH
`define RX_SIDEBAND_REGS_SVH

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_PARAM_A 8'h04
`define REG_PARAM_B 8'h08
`define REG_PARAM_C 8'h0C
`define REG_POWERDOWN 8'h10
`define REG_ERR_EN 8'h14
`define REG_ERR_STAT 8'h18
`define REG_STATUS 8'h1C
`define REG_LANE_STAT 8'h20

// Field positions
`define CTRL_RESYNC 0
`define CTRL_LOOPBACK 1
`define CTRL_TESTMODE 4
`define PA_L 0
`define PA_F 8
`define PA_K 16
`define PB_M 0
`define PB_CS 8
`define PB_N 16
`define PB_NP 24
`define PC_S 0
`define PC_HD 8
`define PC_CF 16
`define ST_SYNC_N 0
`define ST_DEV_ALIGNED 1
`define ST_ALLDEV 2
`define ST_SYSREF 3

// Error types
`define ERR_TYPES 3
`define ERR_CODE 0
`define ERR_DISP 1
`define ERR_UNEXP_K 2

// Reset values
`define RST_L 5'h01
`define RST_F 8'h01
`define RST_K 5'h0F
`define RST_M 8'h01
`define RST_CS 2'h0
`define RST_N 5'h0F
`define RST_NP 5'h0F
`define RST_S 5'h00
`define RST_HD 1'h0
`define RST_CF 5'h00

// Control characters and counts
`define K_CGS 8'hBC
`define K_ILAS_START 8'h1C
`define K_ALIGN 8'h7C
`define K_FRAME 8'hFC
`define K_CONFIG 8'h9C
`define CGS_K_COUNT 3'h4

`endif

// ### logic/rx_sideband_pkg.sv
`include "rx_sideband_regs.svh"
package rx_sideband_pkg;

  typedef enum logic [1:0] {
    lane_cgs = 2'b00,
    lane_wait_ilas = 2'b01,
    lane_aligned_st = 2'b10
  } lane_state_type;

  typedef struct packed {
    logic [31:0] data;
    logic [3:0] kchar;
    logic [3:0] code_err;
    logic [3:0] disp_err;
    logic valid;
  } lane_octets_type;

  typedef struct packed {
    lane_state_type st;
    logic [2:0] kcnt;
    logic [`ERR_TYPES-1:0] err;
  } lane_track_type;

  typedef struct packed {
    logic run;
    logic [7:0] oct;
    logic [4:0] frm;
    logic [3:0] sof;
    logic [3:0] somf;
  } marker_state_type;

endpackage : rx_sideband_pkg

// ### logic/lane_align_tracker.sv
`timescale 1ns/10ps
`include "rx_sideband_regs.svh"
module lane_align_tracker (
  input wire logic clk,
  input wire logic rst_n,
  input rx_sideband_pkg::lane_octets_type octets,
  input wire logic sync_req,
  output logic cgs_done,
  output logic waiting,
  output logic aligned,
  output logic [`ERR_TYPES-1:0] err
);
  import rx_sideband_pkg::*;

  lane_track_type q;
  lane_track_type next_q;

  always_comb begin
    logic [7:0] oc;
    logic kc;
    oc = 8'h00;
    kc = 1'b0;
    next_q = q;
    next_q.err = '0;
    if (octets.valid) begin
      // Earliest octet sits in the top byte
      for (int j = 3; j >= 0; j--) begin
        oc = octets.data[j*8 +: 8];
        kc = octets.kchar[j];
        case (next_q.st)
          lane_cgs: begin
            if (kc && oc == `K_CGS) begin
              if (next_q.kcnt != `CGS_K_COUNT) begin
                next_q.kcnt = next_q.kcnt + 3'h1;
              end
            end else begin
              next_q.kcnt = 3'h0;
            end
          end
          lane_wait_ilas: begin
            if (kc && oc == `K_ILAS_START) begin
              next_q.st = lane_aligned_st; // RQ7
            end
          end
          default: begin
            if (kc && oc != `K_CGS && oc != `K_ILAS_START && oc != `K_ALIGN &&
                oc != `K_FRAME && oc != `K_CONFIG) begin
              next_q.err[`ERR_UNEXP_K] = 1'b1;
            end
          end
        endcase
      end
      next_q.err[`ERR_CODE] = |octets.code_err;
      next_q.err[`ERR_DISP] = |octets.disp_err;
    end
    if (q.st == lane_cgs && q.kcnt == `CGS_K_COUNT && !sync_req) begin
      next_q.st = lane_wait_ilas;
    end
    if (sync_req && q.st != lane_cgs) begin
      next_q.st = lane_cgs;
      next_q.kcnt = 3'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign cgs_done = (q.st != lane_cgs) || (q.kcnt == `CGS_K_COUNT);
  assign waiting = (q.st == lane_wait_ilas);
  assign aligned = (q.st == lane_aligned_st);
  assign err = q.err;

endmodule : lane_align_tracker

// ### logic/frame_marker.sv
`timescale 1ns/10ps
`include "rx_sideband_regs.svh"
module frame_marker (
  input wire logic clk,
  input wire logic rst_n,
  input rx_sideband_pkg::lane_octets_type octets,
  input wire logic armed,
  input wire logic sync_req,
  input wire logic [7:0] f_minus1,
  input wire logic [4:0] k_minus1,
  output logic [3:0] sof,
  output logic [3:0] somf
);
  import rx_sideband_pkg::*;

  marker_state_type q;
  marker_state_type next_q;

  always_comb begin
    next_q = q;
    next_q.sof = 4'h0;
    next_q.somf = 4'h0;
    if (octets.valid) begin
      for (int j = 3; j >= 0; j--) begin
        // Multiframe counting starts on the first ILAS octet
        if (armed && !next_q.run && octets.kchar[j] &&
            octets.data[j*8 +: 8] == `K_ILAS_START) begin
          next_q.run = 1'b1;
          next_q.oct = 8'h00;
          next_q.frm = 5'h00;
        end
        if (next_q.run) begin
          next_q.sof[j] = (next_q.oct == 8'h00); // RQ5
          next_q.somf[j] = (next_q.oct == 8'h00) && (next_q.frm == 5'h00); // RQ6
          if (next_q.oct == f_minus1) begin
            next_q.oct = 8'h00;
            next_q.frm = (next_q.frm == k_minus1) ? 5'h00 : next_q.frm + 5'h01;
          end else begin
            next_q.oct = next_q.oct + 8'h01;
          end
        end
      end
    end
    if (sync_req) begin
      next_q.run = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign sof = q.sof;
  assign somf = q.somf;

endmodule : frame_marker

// ### logic/converter_link_rx_sideband.sv
// Function
// RQ1: Timing reference input is held low outside subclass 1 by the system.
// RQ2: Sync request output is low to request sync, high when none pending.
// RQ3: Link errors never appear on sync request; they go to the interrupt.
// RQ4: Integrator may AND sync requests of several receivers toward converters.
// RQ5: Four frame-start flags, bit 3 for the top data octet, down to bit 0.
// RQ6: Four multiframe-start flags with the same octet mapping.
// RQ7: Device-aligned output rises once every active lane is aligned.
// RQ8: Integrator ANDs all device-aligned outputs into each all-aligned input.
// RQ9: Single device loops its own device-aligned output back to all-aligned.
// RQ10: Lane count 5 bits, octets per frame 8, frames per multiframe 5.
// RQ11: Converter count 8, control bits 2, resolution 5, total bits 5.
// RQ12: Samples per frame 5 bits, high-density flag, control words 5 bits.
// RQ13: Lane powerdown vector, one bit per lane, as software sets it.
// RQ14: Interrupt rises only for detected errors of enabled types.
// RQ15: Four-bit test-mode output mirrors the test-mode register field.
// RQ16: Loopback source may give 32 parallel bits per lane instead of serial data.
// RQ17: Loopback source gives a valid per lane and four control flags per lane.
// RQ18: Loopback source gives four code-error and four disparity flags per lane.
// RQ19: Lane words are big-endian, earliest octet in bits 31:24.
// RQ20: Transport data cannot be stalled; delivered whenever valid is high.
// RQ21: Unused loopback inputs are tied low by the integrator.
// RQ22: Frame flags count only with valid high and align with their word.
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/10ps
`include "rx_sideband_regs.svh"
module converter_link_rx_sideband #(
  parameter int LANES = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic sysref,
  input wire logic alldev_lane_aligned,
  input wire logic [LANES*32-1:0] phy_data,
  input wire logic [LANES*4-1:0] phy_kchar,
  input wire logic [LANES*4-1:0] phy_code_err,
  input wire logic [LANES*4-1:0] phy_disp_err,
  input wire logic [LANES-1:0] phy_valid,
  input wire logic [LANES*32-1:0] loopback_parallel_data,
  input wire logic [LANES-1:0] loopback_lane_valid,
  input wire logic [LANES*4-1:0] loopback_control_char_flags,
  input wire logic [LANES*4-1:0] loopback_code_error_flags,
  input wire logic [LANES*4-1:0] loopback_disparity_flags,
  output logic sync_request_n,
  output logic [3:0] start_of_frame,
  output logic [3:0] start_of_multiframe,
  output logic dev_lane_aligned,
  output logic [LANES*32-1:0] lane_word_to_transport,
  output logic lane_word_valid,
  output logic [4:0] active_lane_count_out,
  output logic [7:0] octets_per_frame_out,
  output logic [4:0] frames_per_multiframe_out,
  output logic [7:0] converter_count_out,
  output logic [1:0] control_bits_out,
  output logic [4:0] converter_resolution_out,
  output logic [4:0] total_bits_per_sample_out,
  output logic [4:0] samples_per_frame_out,
  output logic high_density_flag_out,
  output logic [4:0] control_words_per_frame_out,
  output logic [LANES-1:0] lane_powerdown,
  output logic receiver_irq,
  output logic [3:0] test_mode_out
);
  import rx_sideband_pkg::*;

  if (LANES < 1 || LANES > 24) begin : g_bad_lanes
    $error("LANES must lie between 1 and 24");
  end

  typedef struct packed {
    logic [31:0] rdata;
    logic resync;
    logic loopback;
    logic [3:0] testmode;
    logic [4:0] l;
    logic [7:0] f;
    logic [4:0] k;
    logic [7:0] m;
    logic [1:0] cs;
    logic [4:0] n;
    logic [4:0] np;
    logic [4:0] s;
    logic hd;
    logic [4:0] cf;
    logic [LANES-1:0] powerdown;
    logic [`ERR_TYPES-1:0] err_en;
    logic [`ERR_TYPES-1:0] err_stat;
    logic [1:0] sysref_sync;
    logic [1:0] alldev_sync;
    logic sysref_prev;
    logic sysref_seen;
    logic sync_n;
    logic dev_aligned;
    logic irq;
    logic valid;
    logic [LANES*32-1:0] data;
  } top_state_type;

  top_state_type q;
  top_state_type next_q;

  lane_octets_type src [LANES];
  logic [LANES-1:0] active;
  logic [LANES-1:0] cgs_done;
  logic [LANES-1:0] waiting;
  logic [LANES-1:0] aligned;
  logic [`ERR_TYPES-1:0] lane_err [LANES];

  // Loopback replaces the PHY words lane by lane
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    always_comb begin
      if (q.loopback) begin
        src[i] = {loopback_parallel_data[i*32 +: 32], loopback_control_char_flags[i*4 +: 4],
                  loopback_code_error_flags[i*4 +: 4], loopback_disparity_flags[i*4 +: 4],
                  loopback_lane_valid[i]}; // RQ16 RQ17 RQ18
      end else begin
        src[i] = {phy_data[i*32 +: 32], phy_kchar[i*4 +: 4], phy_code_err[i*4 +: 4],
                  phy_disp_err[i*4 +: 4], phy_valid[i]};
      end
    end

    // Counted lanes that are powered up
    assign active[i] = (5'(i) <= q.l) && !q.powerdown[i];

    // Alignment tracker per lane
    lane_align_tracker u_tracker (
      .clk(clk),
      .rst_n(rst_n),
      .octets(src[i]),
      .sync_req(!q.sync_n),
      .cgs_done(cgs_done[i]),
      .waiting(waiting[i]),
      .aligned(aligned[i]),
      .err(lane_err[i])
    );
  end

  // Frames follow lane 0
  frame_marker u_marker (
    .clk(clk),
    .rst_n(rst_n),
    .octets(src[0]),
    .armed(waiting[0]),
    .sync_req(!q.sync_n),
    .f_minus1(q.f),
    .k_minus1(q.k),
    .sof(start_of_frame),
    .somf(start_of_multiframe)
  );

  always_comb begin
    logic [31:0] rd_word;
    logic [`ERR_TYPES-1:0] new_err;
    logic [`ERR_TYPES-1:0] clr;
    logic wr_hit;
    rd_word = 32'h0000_0000;
    new_err = '0;
    clr = '0;
    wr_hit = 1'b0;
    next_q = q;

    // Pins pass two flip-flops
    next_q.sysref_sync = {q.sysref_sync[0], sysref}; // RQ1
    next_q.alldev_sync = {q.alldev_sync[0], alldev_lane_aligned};
    next_q.sysref_prev = q.sysref_sync[1];
    next_q.resync = 1'b0;

    // Unmapped writes are ignored
    if (reg_write) begin
      case (reg_addr)
        `REG_CTRL: begin
          next_q.resync = reg_wdata[`CTRL_RESYNC];
          next_q.loopback = reg_wdata[`CTRL_LOOPBACK];
          next_q.testmode = reg_wdata[`CTRL_TESTMODE +: 4];
        end
        `REG_PARAM_A: begin
          next_q.l = reg_wdata[`PA_L +: 5];
          next_q.f = reg_wdata[`PA_F +: 8];
          next_q.k = reg_wdata[`PA_K +: 5];
        end
        `REG_PARAM_B: begin
          next_q.m = reg_wdata[`PB_M +: 8];
          next_q.cs = reg_wdata[`PB_CS +: 2];
          next_q.n = reg_wdata[`PB_N +: 5];
          next_q.np = reg_wdata[`PB_NP +: 5];
        end
        `REG_PARAM_C: begin
          next_q.s = reg_wdata[`PC_S +: 5];
          next_q.hd = reg_wdata[`PC_HD];
          next_q.cf = reg_wdata[`PC_CF +: 5];
        end
        `REG_POWERDOWN: next_q.powerdown = reg_wdata[LANES-1:0]; // RQ13
        `REG_ERR_EN: next_q.err_en = reg_wdata[`ERR_TYPES-1:0];
        `REG_ERR_STAT: clr = reg_wdata[`ERR_TYPES-1:0];
        `REG_STATUS: wr_hit = reg_wdata[`ST_SYSREF];
        default: wr_hit = 1'b0;
      endcase
    end

    // Errors of active lanes only
    for (int i = 0; i < LANES; i++) begin
      if (active[i]) begin
        new_err = new_err | lane_err[i];
      end
    end
    // A fresh error beats a clear in the same cycle
    next_q.err_stat = (q.err_stat & ~clr) | new_err; // RQ3
    next_q.irq = |(next_q.err_stat & next_q.err_en); // RQ14
    // Sticky sysref edge, set wins
    next_q.sysref_seen = (q.sysref_seen && !wr_hit) || (q.sysref_sync[1] && !q.sysref_prev);

    // Request sync until every active lane has seen its comma run
    next_q.sync_n = !q.resync && (&(cgs_done | ~active)); // RQ2
    // Resync holds aligned low
    next_q.dev_aligned = &(aligned | ~active) && q.sync_n && !q.resync; // RQ7
    // No ready from the sink: words go out whenever valid
    next_q.valid = src[0].valid && q.dev_aligned && q.alldev_sync[1]; // RQ20 RQ22
    // Lane words pass unchanged
    for (int i = 0; i < LANES; i++) begin
      next_q.data[i*32 +: 32] = src[i].data; // RQ19
    end

    // Read word for the next cycle
    case (reg_addr)
      `REG_CTRL: begin
        rd_word[`CTRL_LOOPBACK] = q.loopback;
        rd_word[`CTRL_TESTMODE +: 4] = q.testmode;
      end
      `REG_PARAM_A: begin
        rd_word[`PA_L +: 5] = q.l;
        rd_word[`PA_F +: 8] = q.f;
        rd_word[`PA_K +: 5] = q.k;
      end
      `REG_PARAM_B: begin
        rd_word[`PB_M +: 8] = q.m;
        rd_word[`PB_CS +: 2] = q.cs;
        rd_word[`PB_N +: 5] = q.n;
        rd_word[`PB_NP +: 5] = q.np;
      end
      `REG_PARAM_C: begin
        rd_word[`PC_S +: 5] = q.s;
        rd_word[`PC_HD] = q.hd;
        rd_word[`PC_CF +: 5] = q.cf;
      end
      `REG_POWERDOWN: rd_word[LANES-1:0] = q.powerdown;
      `REG_ERR_EN: rd_word[`ERR_TYPES-1:0] = q.err_en;
      `REG_ERR_STAT: rd_word[`ERR_TYPES-1:0] = q.err_stat;
      `REG_STATUS: begin
        rd_word[`ST_SYNC_N] = q.sync_n;
        rd_word[`ST_DEV_ALIGNED] = q.dev_aligned;
        rd_word[`ST_ALLDEV] = q.alldev_sync[1];
        rd_word[`ST_SYSREF] = q.sysref_seen;
      end
      `REG_LANE_STAT: rd_word[LANES-1:0] = aligned;
      default: rd_word = 32'h0000_0000;
    endcase
    next_q.rdata = reg_read ? rd_word : 32'h0000_0000;
  end

  // Parameters reset to defaults
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.l <= `RST_L;
      q.f <= `RST_F;
      q.k <= `RST_K;
      q.m <= `RST_M;
      q.cs <= `RST_CS;
      q.n <= `RST_N;
      q.np <= `RST_NP;
      q.s <= `RST_S;
      q.hd <= `RST_HD;
      q.cf <= `RST_CF;
    end else begin
      q <= next_q;
    end
  end

  // Outputs straight from flops
  assign reg_rdata = q.rdata;
  assign sync_request_n = q.sync_n; // RQ2
  assign dev_lane_aligned = q.dev_aligned; // RQ7
  assign lane_word_to_transport = q.data;
  assign lane_word_valid = q.valid;
  assign active_lane_count_out = q.l; // RQ10
  assign octets_per_frame_out = q.f; // RQ10
  assign frames_per_multiframe_out = q.k; // RQ10
  assign converter_count_out = q.m; // RQ11
  assign control_bits_out = q.cs; // RQ11
  assign converter_resolution_out = q.n; // RQ11
  assign total_bits_per_sample_out = q.np; // RQ11
  assign samples_per_frame_out = q.s; // RQ12
  assign high_density_flag_out = q.hd; // RQ12
  assign control_words_per_frame_out = q.cf; // RQ12
  assign lane_powerdown = q.powerdown; // RQ13
  assign receiver_irq = q.irq; // RQ14
  assign test_mode_out = q.testmode; // RQ15

endmodule : converter_link_rx_sideband

// ### testbench/rx_sideband_monitor.sv
`timescale 1ns/10ps
`include "rx_sideband_regs.svh"
module rx_sideband_monitor #(
  parameter int LANES = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic [LANES*32-1:0] phy_data,
  input wire logic [LANES*4-1:0] phy_code_err,
  input wire logic [LANES-1:0] phy_valid,
  input wire logic [LANES*32-1:0] loopback_parallel_data,
  input wire logic sync_request_n,
  input wire logic [3:0] start_of_frame,
  input wire logic [3:0] start_of_multiframe,
  input wire logic dev_lane_aligned,
  input wire logic [LANES*32-1:0] lane_word_to_transport,
  input wire logic lane_word_valid,
  input wire logic [4:0] active_lane_count_out,
  input wire logic [LANES-1:0] lane_powerdown,
  input wire logic receiver_irq,
  input wire logic [3:0] test_mode_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic wr_ctrl, wr_pa, wr_pd, wr_en, any_valid;
  logic [3:0] wd_tm;
  logic [4:0] wd_l;
  logic [LANES-1:0] wd_pd;
  logic lb_on;
  logic [LANES*32-1:0] src_data;
  assign wr_ctrl = reg_write && reg_addr == `REG_CTRL;
  assign wr_pa = reg_write && reg_addr == `REG_PARAM_A;
  assign wr_pd = reg_write && reg_addr == `REG_POWERDOWN;
  assign wr_en = reg_write && reg_addr == `REG_ERR_EN;
  assign any_valid = |phy_valid;
  assign wd_tm = reg_wdata[`CTRL_TESTMODE +: 4];
  assign wd_l = reg_wdata[4:0];
  assign wd_pd = reg_wdata[LANES-1:0];
  assign src_data = lb_on ? loopback_parallel_data : phy_data;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lb_on <= 1'b0;
    end else if (wr_ctrl) begin
      lb_on <= reg_wdata[`CTRL_LOOPBACK];
    end
  end

  AST_SYNC_HELD: assert property (!sync_request_n && !any_valid |=> !sync_request_n)
    else $error("sync request released without lane words");
  AST_ERR_NO_SYNC: assert property (sync_request_n && (|phy_code_err) && !wr_ctrl |=> sync_request_n)
    else $error("link error shown on sync request");
  AST_SOMF_IN_SOF: assert property ((start_of_multiframe & ~start_of_frame) == 4'h0)
    else $error("multiframe start outside frame start");
  AST_SOF_VALID: assert property (|start_of_frame |-> $past(any_valid))
    else $error("frame start without a valid word");
  AST_ALIGN_AFTER_SYNC: assert property ($rose(dev_lane_aligned) |-> sync_request_n)
    else $error("aligned while sync requested");
  AST_VALID_GATED: assert property (lane_word_valid |-> $past(dev_lane_aligned))
    else $error("word valid before alignment");
  AST_BIG_ENDIAN: assert property (lane_word_valid |-> lane_word_to_transport == $past(src_data))
    else $error("transport word differs from lane word");
  AST_IRQ_MASKED: assert property (wr_en && reg_wdata == 32'h0 |=> ##1 !receiver_irq)
    else $error("interrupt with all errors disabled");
  AST_TESTMODE: assert property (wr_ctrl ##1 !wr_ctrl |=> test_mode_out == $past(wd_tm, 2))
    else $error("test mode output not updated");
  AST_POWERDOWN: assert property (wr_pd ##1 !wr_pd |=> lane_powerdown == $past(wd_pd, 2))
    else $error("powerdown output not updated");
  AST_LANE_COUNT: assert property (wr_pa ##1 !wr_pa |=> active_lane_count_out == $past(wd_l, 2))
    else $error("lane count output not updated");

  C_STREAM: cover property (lane_word_valid);
  C_IRQ: cover property ($rose(receiver_irq));
  C_ALIGN: cover property ($rose(dev_lane_aligned));
endmodule : rx_sideband_monitor

bind converter_link_rx_sideband rx_sideband_monitor #(.LANES(LANES)) mon (.clk(clk),
  .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .phy_data(phy_data), .phy_code_err(phy_code_err), .phy_valid(phy_valid),
  .loopback_parallel_data(loopback_parallel_data),
  .sync_request_n(sync_request_n), .start_of_frame(start_of_frame),
  .start_of_multiframe(start_of_multiframe), .dev_lane_aligned(dev_lane_aligned),
  .lane_word_to_transport(lane_word_to_transport), .lane_word_valid(lane_word_valid),
  .active_lane_count_out(active_lane_count_out), .lane_powerdown(lane_powerdown),
  .receiver_irq(receiver_irq), .test_mode_out(test_mode_out));

// ### testbench/adc_lane_model.sv
`timescale 1ns/10ps
module adc_lane_model #(
  parameter int LANES = 2
) (
  input wire logic clk,
  input wire logic [1:0] mode,
  input wire logic inject_err,
  output logic [LANES*32-1:0] data,
  output logic [LANES*4-1:0] kchar,
  output logic [LANES*4-1:0] code_err,
  output logic [LANES*4-1:0] disp_err,
  output logic [LANES-1:0] valid
);
  logic [7:0] cnt = 8'h00;
  initial begin
    data = '0;
    kchar = '0;
    code_err = '0;
    disp_err = '0;
    valid = '0;
  end
  // Modes: idle, sync characters, one lane-alignment start word, user data
  always @(posedge clk) begin
    cnt <= cnt + 8'h04;
    code_err <= '0;
    disp_err <= '0;
    valid <= {LANES{mode != 2'h0}};
    for (int i = 0; i < LANES; i++) begin
      case (mode)
        2'h0: data[i*32 +: 32] <= ~data[i*32 +: 32];
        2'h1: data[i*32 +: 32] <= 32'hBCBCBCBC;
        2'h2: data[i*32 +: 32] <= 32'h1C000000;
        default: data[i*32 +: 32] <= {cnt, cnt + 8'h01, cnt + 8'h02, cnt + 8'h03} ^ {32{i[0]}};
      endcase
      kchar[i*4 +: 4] <= (mode == 2'h1) ? 4'hF : ((mode == 2'h2) ? 4'h8 : 4'h0);
      if (mode == 2'h3 && inject_err) begin
        code_err[i*4 +: 4] <= 4'h1;
      end
    end
  end
endmodule : adc_lane_model

// ### testbench/testbench.sv
`timescale 1ns/10ps
`include "rx_sideband_regs.svh"
module testbench;
  localparam int LANES = 2;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic sysref = 1'b0;
  logic [1:0] mode = 2'h0;
  logic inject_err = 1'b0;
  logic [LANES*32-1:0] lb_data = '0;
  logic [LANES-1:0] lb_valid = '0;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [31:0] reg_rdata, rd_val;
  logic [LANES*32-1:0] phy_data, lane_word_to_transport, prev_data;
  logic [LANES*4-1:0] phy_kchar, phy_code_err, phy_disp_err;
  logic [LANES-1:0] phy_valid, lane_powerdown;
  logic sync_request_n, dev_lane_aligned, lane_word_valid, receiver_irq, hd;
  logic [3:0] sof, somf, test_mode_out;
  logic [4:0] l_out, k_out, n_out, np_out, s_out, cf_out;
  logic [7:0] f_out, m_out;
  logic [1:0] cs_out;
  logic [48:0] params;
  assign params = {l_out, f_out, k_out, m_out, cs_out, n_out, np_out, s_out, hd, cf_out};

  always #10 clk = ~clk;
  always @(posedge clk) prev_data <= phy_data;

  adc_lane_model #(.LANES(LANES)) adc (.clk(clk), .mode(mode), .inject_err(inject_err),
    .data(phy_data), .kchar(phy_kchar), .code_err(phy_code_err), .disp_err(phy_disp_err),
    .valid(phy_valid));

  converter_link_rx_sideband #(.LANES(LANES)) DUT (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .sysref(sysref),
    .alldev_lane_aligned(dev_lane_aligned),
    .phy_data(phy_data), .phy_kchar(phy_kchar), .phy_code_err(phy_code_err),
    .phy_disp_err(phy_disp_err), .phy_valid(phy_valid),
    .loopback_parallel_data(lb_data), .loopback_lane_valid(lb_valid),
    .loopback_control_char_flags('0), .loopback_code_error_flags('0),
    .loopback_disparity_flags('0),
    .sync_request_n(sync_request_n), .start_of_frame(sof), .start_of_multiframe(somf),
    .dev_lane_aligned(dev_lane_aligned), .lane_word_to_transport(lane_word_to_transport),
    .lane_word_valid(lane_word_valid), .active_lane_count_out(l_out),
    .octets_per_frame_out(f_out), .frames_per_multiframe_out(k_out),
    .converter_count_out(m_out), .control_bits_out(cs_out), .converter_resolution_out(n_out),
    .total_bits_per_sample_out(np_out), .samples_per_frame_out(s_out),
    .high_density_flag_out(hd), .control_words_per_frame_out(cf_out),
    .lane_powerdown(lane_powerdown), .receiver_irq(receiver_irq), .test_mode_out(test_mode_out));

  task check(input string what, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask : rd

  task test_reset;
    check("sync_n", 1'b0, sync_request_n);
    check("params", {5'h01, 8'h01, 5'h0F, 8'h01, 2'h0, 5'h0F, 5'h0F, 5'h00, 1'b0, 5'h00}, params);
    check("irq", 1'b0, receiver_irq);
    rd(8'h40);
    check("unmapped", 32'h0, rd_val);
    $display("test_reset done");
  endtask : test_reset

  task test_params;
    wr(`REG_PARAM_B, 32'h0E0D0205);
    wr(`REG_PARAM_C, 32'h00030107);
    wr(`REG_PARAM_A, 32'h000F0101);
    wr(`REG_CTRL, 32'h000000A0);
    wr(`REG_POWERDOWN, 32'h00000002);
    repeat (2) @(negedge clk);
    check("params", {5'h01, 8'h01, 5'h0F, 8'h05, 2'h2, 5'h0D, 5'h0E, 5'h07, 1'b1, 5'h03}, params);
    check("test_mode", 4'hA, test_mode_out);
    check("powerdown", 2'h2, lane_powerdown);
    rd(`REG_PARAM_B);
    check("param_b", 32'h0E0D0205, rd_val);
    wr(`REG_CTRL, 32'h0);
    wr(`REG_POWERDOWN, 32'h0);
    $display("test_params done");
  endtask : test_params

  task test_link;
    int i;
    @(posedge clk) mode <= 2'h1;
    for (i = 0; i < 40 && sync_request_n !== 1'b1; i++) @(negedge clk);
    check("sync_release", 1'b1, sync_request_n);
    @(posedge clk) mode <= 2'h2;
    @(posedge clk) mode <= 2'h3;
    for (i = 0; i < 10 && somf === 4'h0; i++) @(negedge clk);
    check("sof", 4'hA, sof);
    check("somf", 4'h8, somf);
    for (i = 0; i < 10 && dev_lane_aligned !== 1'b1; i++) @(negedge clk);
    check("dev_aligned", 1'b1, dev_lane_aligned);
    for (i = 0; i < 10 && lane_word_valid !== 1'b1; i++) @(negedge clk);
    check("word_valid", 1'b1, lane_word_valid);
    check("word", prev_data, lane_word_to_transport);
    check("sof_stream", 4'hA, sof);
    $display("test_link done");
  endtask : test_link

  task test_errors;
    @(posedge clk) sysref <= 1'b1;
    repeat (3) @(posedge clk);
    sysref <= 1'b0;
    wr(`REG_ERR_EN, 32'h2);
    @(posedge clk) inject_err <= 1'b1;
    @(posedge clk) inject_err <= 1'b0;
    repeat (4) @(negedge clk);
    check("irq_masked", 1'b0, receiver_irq);
    check("sync_kept", 1'b1, sync_request_n);
    rd(`REG_ERR_STAT);
    check("err_stat", 32'h1, rd_val);
    wr(`REG_ERR_EN, 32'h1);
    repeat (3) @(negedge clk);
    check("irq", 1'b1, receiver_irq);
    wr(`REG_ERR_STAT, 32'h1);
    repeat (3) @(negedge clk);
    check("irq_cleared", 1'b0, receiver_irq);
    rd(`REG_STATUS);
    check("sysref_seen", 1'b1, rd_val[`ST_SYSREF]);
    wr(`REG_ERR_EN, 32'h0);
    $display("test_errors done");
  endtask : test_errors

  task test_loopback;
    lb_data <= 64'h0123_4567_89AB_CDEF;
    wr(`REG_CTRL, 32'h2);
    repeat (2) @(negedge clk);
    check("lb_idle", 1'b0, lane_word_valid);
    @(posedge clk) lb_valid <= 2'h3;
    repeat (2) @(negedge clk);
    check("lb_valid", 1'b1, lane_word_valid);
    check("lb_word", 64'h0123_4567_89AB_CDEF, lane_word_to_transport);
    wr(`REG_CTRL, 32'h0);
    $display("test_loopback done");
  endtask : test_loopback

  task complete_run;
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    #200000;
    error_cnt++;
    $display("BAD watchdog expected end seen hang");
    complete_run();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    test_reset();
    test_params();
    test_link();
    test_errors();
    test_loopback();
    complete_run();
  end
endmodule : testbench
